// File: src/snl_fifo.sv
`timescale 1ns/100ps
module snl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic flush,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_r;
   logic [AW-1:0] rdPtr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   assign inReady = (count_r != (AW+1)'(DEPTH));
   assign outValid = (count_r != '0);
   assign outData = mem[rdPtr_r];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_r] <= inData;
      end
   end

   // Flush drops all contents when the transfer ends
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else if (flush) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
         end
         if (pop) begin
            rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// File: src/snl_latch_read.sv
`timescale 1ns/100ps
module snl_latch_read #(
   // Identification bytes; values are arbitrary
   parameter logic [7:0] MAKER_CODE = 8'h5a,
   parameter logic [7:0] PART_CODE_BYTE = 8'ha5
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Serial link pins
   input wire logic sclkPin,
   input wire logic csPinN,
   input wire logic [3:0] ioIn,
   output logic [3:0] ioOut,
   output logic [3:0] ioOe,
   // Configuration
   input wire logic quadLinesEnable,
   input wire logic otpAccessEnable,
   input wire logic [127:0] uniqueIdentifier,
   // Array modification handshake
   input wire logic modifyReq,
   output logic modifyGrant,
   // Array to cache load
   output logic pageLoadStart,
   output logic [23:0] pageLoadAddr,
   output logic pageLoadAbort,
   // Cache read port, data in the same cycle as address
   output logic [11:0] cacheAddr,
   input wire logic [7:0] cacheData,
   // Status
   output logic writeEnableLatch,
   output logic busy
);
   snl_pkg::snl_state_e state_r;
   logic sclkMeta, sclkSync, sclkDly;
   logic csMeta, csSync, csDly;
   logic [3:0] ioMeta, ioSync;
   logic rise, fall, csRise, capture;
   logic [7:0] opcode_r;
   logic [7:0] opcNext;
   logic [5:0] cnt_r;
   logic [31:0] addr_r;
   logic [31:0] addrNext;
   logic dtr_r;
   logic [2:0] width_r;
   logic pageArmed_r;
   logic wel_r;
   logic busy_r;
   logic [9:0] busyCnt_r;
   logic [23:0] loadedPage_r;
   logic pageLoadStart_r, pageLoadAbort_r, modifyGrant_r;
   logic [23:0] pageLoadAddr_r;
   logic [11:0] cacheAddr_r;
   logic [11:0] col_r;
   logic [7:0] featAddr_r;
   logic [1:0] idIdx_r;
   logic fetchPend_r, useCache_r;
   logic [7:0] pendByte_r;
   logic fetchOn, fetchGo;
   logic fifoInReady, fifoOutValid, fifoPop;
   logic [7:0] fifoInData, fifoOutData;
   logic [7:0] sr_r;
   logic [3:0] remain_r;
   logic launch;
   logic [7:0] launchByte;
   logic [3:0] ioOut_r, ioOe_r;
   logic setCmd, clrCmd, rstCmd, addrDone;

   // Lanes carried by each read opcode
   function automatic logic [2:0] laneWidth(input logic [7:0] opc);
      if (opc == snl_pkg::OPC_READ_X2) begin
         return 3'h2;
      end else if (opc == snl_pkg::OPC_READ_X4 || opc == snl_pkg::OPC_READ_DTR) begin
         return 3'h4;
      end
      return 3'h1;
   endfunction

   // Address captures that follow the opcode
   function automatic logic [5:0] addrUnits(input logic [7:0] opc);
      unique case (opc)
         snl_pkg::OPC_PAGE_READ: return snl_pkg::PAGE_ADDR_BITS;
         snl_pkg::OPC_READ_DTR: return snl_pkg::DTR_ADDR_NIBBLES;
         snl_pkg::OPC_GET_FEAT: return snl_pkg::FEAT_ADDR_BITS;
         snl_pkg::OPC_READ, snl_pkg::OPC_READ_FAST, snl_pkg::OPC_READ_X2,
         snl_pkg::OPC_READ_X4: return snl_pkg::COL_ADDR_BITS;
         default: return 6'h00;
      endcase
   endfunction

   // Top of a byte as it appears on the lanes
   function automatic logic [3:0] laneOut(input logic [7:0] b, input logic [2:0] w);
      if (w == 3'h4) begin
         return b[7:4];
      end else if (w == 3'h2) begin
         return {2'b00, b[7:6]};
      end
      return {2'b00, b[7], 1'b0};
   endfunction

   function automatic logic [11:0] colStep(input logic [11:0] c);
      return (c == snl_pkg::CACHE_LAST) ? 12'h000 : c + 12'h001;
   endfunction

   // Pin synchronisers; logic reads the second stage, and the third stage only for edge detection
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sclkMeta <= 1'b0;
         sclkSync <= 1'b0;
         sclkDly <= 1'b0;
         csMeta <= 1'b1;
         csSync <= 1'b1;
         csDly <= 1'b1;
         ioMeta <= 4'h0;
         ioSync <= 4'h0;
      end else begin
         sclkMeta <= sclkPin;
         sclkSync <= sclkMeta;
         sclkDly <= sclkSync;
         csMeta <= csPinN;
         csSync <= csMeta;
         csDly <= csSync;
         ioMeta <= ioIn;
         ioSync <= ioMeta;
      end
   end

   assign rise = sclkSync && !sclkDly && !csSync;
   assign fall = !sclkSync && sclkDly && !csSync;
   assign csRise = csSync && !csDly;
   assign opcNext = {opcode_r[6:0], ioSync[0]};
   // DTR address takes a nibble on every edge after the opcode
   assign capture = rise || (fall && dtr_r && cnt_r[0]);
   assign addrNext = dtr_r ? {addr_r[27:0], ioSync} : {addr_r[30:0], ioSync[0]};
   assign addrDone = (state_r == snl_pkg::ST_ADDR) && capture
                     && (cnt_r == addrUnits(opcode_r) - 6'h01);
   assign setCmd = (state_r == snl_pkg::ST_OPC) && rise && (cnt_r == snl_pkg::OPC_BITS - 6'h01)
                   && (opcNext == snl_pkg::OPC_SET_LATCH);
   assign clrCmd = (state_r == snl_pkg::ST_OPC) && rise && (cnt_r == snl_pkg::OPC_BITS - 6'h01)
                   && (opcNext == snl_pkg::OPC_CLR_LATCH);
   assign rstCmd = (state_r == snl_pkg::ST_OPC) && rise && (cnt_r == snl_pkg::OPC_BITS - 6'h01)
                   && (opcNext == snl_pkg::OPC_RESET);

   // Command sequencer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= snl_pkg::ST_IDLE;
         opcode_r <= 8'h00;
         cnt_r <= 6'h00;
         addr_r <= 32'h0000_0000;
         dtr_r <= 1'b0;
         width_r <= 3'h1;
      end else if (csSync) begin
         state_r <= snl_pkg::ST_IDLE;
         dtr_r <= 1'b0;
      end else begin
         unique case (state_r)
            snl_pkg::ST_IDLE: begin
               state_r <= snl_pkg::ST_OPC;
               cnt_r <= 6'h00;
            end
            snl_pkg::ST_OPC: begin
               if (rise) begin
                  opcode_r <= opcNext;
                  cnt_r <= cnt_r + 6'h01;
                  if (cnt_r == snl_pkg::OPC_BITS - 6'h01) begin
                     cnt_r <= 6'h00;
                     width_r <= laneWidth(opcNext);
                     dtr_r <= (opcNext == snl_pkg::OPC_READ_DTR);
                     addr_r <= 32'h0000_0000;
                     if ((opcNext == snl_pkg::OPC_READ_X4 || opcNext == snl_pkg::OPC_READ_DTR)
                         && !quadLinesEnable) begin
                        state_r <= snl_pkg::ST_WAITCS;
                     end else if (opcNext == snl_pkg::OPC_PAGE_READ && busy_r) begin
                        state_r <= snl_pkg::ST_WAITCS;
                     end else if (addrUnits(opcNext) != 6'h00) begin
                        state_r <= snl_pkg::ST_ADDR;
                     end else if (opcNext == snl_pkg::OPC_READ_ID) begin
                        state_r <= snl_pkg::ST_DUMMY;
                     end else begin
                        state_r <= snl_pkg::ST_WAITCS;
                     end
                  end
               end
            end
            snl_pkg::ST_ADDR: begin
               if (capture) begin
                  addr_r <= addrNext;
                  cnt_r <= cnt_r + 6'h01;
                  if (addrDone) begin
                     cnt_r <= 6'h00;
                     if (opcode_r == snl_pkg::OPC_PAGE_READ) begin
                        state_r <= snl_pkg::ST_WAITCS;
                     end else if (opcode_r == snl_pkg::OPC_GET_FEAT) begin
                        state_r <= snl_pkg::ST_DATA;
                     end else begin
                        state_r <= snl_pkg::ST_DUMMY;
                     end
                  end
               end
            end
            snl_pkg::ST_DUMMY: begin
               if (rise) begin
                  cnt_r <= cnt_r + 6'h01;
                  if (cnt_r == snl_pkg::DUMMY_CLKS - 6'h01) begin
                     state_r <= snl_pkg::ST_DATA;
                  end
               end
            end
            snl_pkg::ST_DATA: begin
               state_r <= snl_pkg::ST_DATA;
            end
            snl_pkg::ST_WAITCS: begin
               state_r <= snl_pkg::ST_WAITCS;
            end
         endcase
      end
   end

   // Page address held until chip select rises
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pageArmed_r <= 1'b0;
      end else if (addrDone && opcode_r == snl_pkg::OPC_PAGE_READ) begin
         pageArmed_r <= 1'b1;
      end else if (csRise) begin
         pageArmed_r <= 1'b0;
      end
   end

   // Array-to-cache load and busy time
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_r <= 1'b0;
         busyCnt_r <= 10'h000;
         loadedPage_r <= 24'h000000;
         pageLoadStart_r <= 1'b0;
         pageLoadAbort_r <= 1'b0;
         pageLoadAddr_r <= 24'h000000;
      end else begin
         pageLoadStart_r <= 1'b0;
         pageLoadAbort_r <= 1'b0;
         if (rstCmd) begin
            busy_r <= 1'b0;
            busyCnt_r <= 10'h000;
            pageLoadAbort_r <= busy_r;
         end else if (csRise && pageArmed_r) begin
            busy_r <= 1'b1;
            busyCnt_r <= 10'(snl_pkg::ARRAY_BUSY_CYC - 1);
            loadedPage_r <= addr_r[23:0];
            pageLoadAddr_r <= addr_r[23:0];
            pageLoadStart_r <= 1'b1;
         end else if (busy_r) begin
            busyCnt_r <= busyCnt_r - 10'h001;
            if (busyCnt_r == 10'h000) begin
               busy_r <= 1'b0;
            end
         end
      end
   end

   // Write enable latch; a set in the same cycle as a grant wins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wel_r <= 1'b0;
         modifyGrant_r <= 1'b0;
      end else begin
         modifyGrant_r <= modifyReq && wel_r;
         if (setCmd) begin
            wel_r <= 1'b1;
         end else if (clrCmd) begin
            wel_r <= 1'b0;
         end else if (rstCmd) begin
            wel_r <= 1'b0;
         end else if (modifyReq && wel_r) begin
            wel_r <= 1'b0;
         end
      end
   end

   // Fetch engine keeps the buffer ahead of the output shifter
   assign fetchOn = (state_r == snl_pkg::ST_DUMMY || state_r == snl_pkg::ST_DATA) && !csSync;
   assign fetchGo = fetchOn && fifoInReady && !fetchPend_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         col_r <= 12'h000;
         featAddr_r <= 8'h00;
         idIdx_r <= 2'h0;
         fetchPend_r <= 1'b0;
         useCache_r <= 1'b0;
         pendByte_r <= 8'h00;
         cacheAddr_r <= 12'h000;
      end else if (csSync) begin
         fetchPend_r <= 1'b0;
         idIdx_r <= 2'h0;
      end else begin
         if (addrDone) begin
            col_r <= addrNext[11:0];
            featAddr_r <= addrNext[7:0];
         end
         fetchPend_r <= fetchGo;
         if (fetchGo) begin
            cacheAddr_r <= col_r;
            col_r <= colStep(col_r);
            useCache_r <= 1'b0;
            if (opcode_r == snl_pkg::OPC_READ_ID) begin
               if (idIdx_r != 2'h2) begin
                  idIdx_r <= idIdx_r + 2'h1;
               end
               pendByte_r <= (idIdx_r == 2'h0) ? MAKER_CODE :
                             (idIdx_r == 2'h1) ? PART_CODE_BYTE : 8'h00;
            end else if (opcode_r == snl_pkg::OPC_GET_FEAT) begin
               pendByte_r <= 8'h00;
               if (featAddr_r == snl_pkg::FEAT_STATUS) begin
                  pendByte_r[snl_pkg::STAT_BUSY_BIT] <= busy_r;
                  pendByte_r[snl_pkg::STAT_WEL_BIT] <= wel_r;
               end else if (featAddr_r == snl_pkg::FEAT_CONFIG) begin
                  pendByte_r[snl_pkg::CFG_QUAD_BIT] <= quadLinesEnable;
                  pendByte_r[snl_pkg::CFG_OTP_BIT] <= otpAccessEnable;
               end
            end else if (otpAccessEnable && loadedPage_r == snl_pkg::UID_PAGE) begin
               // Identifier repeats every 32 bytes, complement in the upper half
               pendByte_r <= uniqueIdentifier[8'(8'd127 - {col_r[3:0], 3'b000}) -: 8]
                             ^ {8{col_r[4]}};
            end else begin
               useCache_r <= 1'b1;
            end
         end
      end
   end

   assign fifoInData = useCache_r ? cacheData : pendByte_r;

   snl_fifo #(
      .WIDTH(snl_pkg::FIFO_WIDTH),
      .DEPTH(snl_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .flush(csSync),
      .inValid(fetchPend_r),
      .inReady(fifoInReady),
      .inData(fifoInData),
      .outValid(fifoOutValid),
      .outReady(fifoPop),
      .outData(fifoOutData)
   );

   // SDR launches on falling edges; DTR launches a byte's halves on rise then fall
   assign launch = (state_r == snl_pkg::ST_DATA) &&
                   (dtr_r ? ((rise && remain_r == 4'h0) || (fall && remain_r != 4'h0))
                          : fall);
   assign fifoPop = launch && (remain_r == 4'h0) && fifoOutValid;
   // An empty buffer only happens when the link outruns the cache port
   assign launchByte = fifoOutValid ? fifoOutData : snl_pkg::IDLE_BYTE;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sr_r <= 8'h00;
         remain_r <= 4'h0;
         ioOut_r <= 4'h0;
      end else if (csSync || state_r != snl_pkg::ST_DATA) begin
         remain_r <= 4'h0;
      end else if (launch) begin
         if (remain_r == 4'h0) begin
            ioOut_r <= laneOut(launchByte, width_r);
            sr_r <= launchByte << width_r;
            remain_r <= 4'h8 - {1'b0, width_r};
         end else begin
            ioOut_r <= laneOut(sr_r, width_r);
            sr_r <= sr_r << width_r;
            remain_r <= remain_r - {1'b0, width_r};
         end
      end
   end

   // Lanes are driven only in the data phase of a read
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ioOe_r <= 4'h0;
      end else if (csSync || state_r != snl_pkg::ST_DATA) begin
         ioOe_r <= 4'h0;
      end else begin
         ioOe_r <= (width_r == 3'h4) ? 4'hf : (width_r == 3'h2) ? 4'h3 : 4'h2;
      end
   end

   assign ioOut = ioOut_r;
   assign ioOe = ioOe_r;
   assign modifyGrant = modifyGrant_r;
   assign pageLoadStart = pageLoadStart_r;
   assign pageLoadAddr = pageLoadAddr_r;
   assign pageLoadAbort = pageLoadAbort_r;
   assign cacheAddr = cacheAddr_r;
   assign writeEnableLatch = wel_r;
   assign busy = busy_r;
endmodule

// File: src/snl_pkg.sv
package snl_pkg;
   // Opcodes
   localparam logic [7:0] OPC_SET_LATCH = 8'h06;
   localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
   localparam logic [7:0] OPC_PAGE_READ = 8'h13;
   localparam logic [7:0] OPC_READ = 8'h03;
   localparam logic [7:0] OPC_READ_FAST = 8'h0b;
   localparam logic [7:0] OPC_READ_X2 = 8'h3b;
   localparam logic [7:0] OPC_READ_X4 = 8'h6b;
   localparam logic [7:0] OPC_READ_DTR = 8'hee;
   localparam logic [7:0] OPC_READ_ID = 8'h9f;
   localparam logic [7:0] OPC_GET_FEAT = 8'h0f;
   localparam logic [7:0] OPC_RESET = 8'hff;
   // Phase lengths, in captures or rising edges
   localparam logic [5:0] OPC_BITS = 6'h08;
   localparam logic [5:0] PAGE_ADDR_BITS = 6'h18;
   localparam logic [5:0] COL_ADDR_BITS = 6'h10;
   localparam logic [5:0] DTR_ADDR_NIBBLES = 6'h08;
   localparam logic [5:0] FEAT_ADDR_BITS = 6'h08;
   localparam logic [5:0] DUMMY_CLKS = 6'h08;
   // Cache, special pages and feature addresses
   localparam logic [11:0] CACHE_LAST = 12'h83f;
   localparam logic [23:0] UID_PAGE = 24'h000006;
   localparam logic [23:0] PARAM_PAGE = 24'h000004;
   localparam logic [7:0] FEAT_STATUS = 8'hc0;
   localparam logic [7:0] FEAT_CONFIG = 8'hb0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_WEL_BIT = 1;
   localparam int CFG_QUAD_BIT = 0;
   localparam int CFG_OTP_BIT = 6;
   localparam logic [7:0] IDLE_BYTE = 8'hff;
   // Timing
   localparam int CLK_NS = 50;
   localparam int ARRAY_TO_CACHE_BUSY_TIME_NS = 25000;
   localparam int ARRAY_BUSY_CYC = (ARRAY_TO_CACHE_BUSY_TIME_NS + CLK_NS - 1) / CLK_NS;
   // Data buffer
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 8;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_OPC = 3'h1,
      ST_ADDR = 3'h3,
      ST_DUMMY = 3'h2,
      ST_DATA = 3'h6,
      ST_WAITCS = 3'h7
   } snl_state_e;
endpackage

// File: test/snl_chk.sv
`timescale 1ns/100ps
module snl_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Design ports
   input wire logic csPinN,
   input wire logic [3:0] ioOe,
   input wire logic modifyReq,
   input wire logic modifyGrant,
   input wire logic pageLoadStart,
   input wire logic pageLoadAbort,
   input wire logic [11:0] cacheAddr,
   input wire logic writeEnableLatch,
   input wire logic busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_noGrant; modifyReq && !writeEnableLatch |=> !modifyGrant; endproperty
   a_noGrant: assert property (p_noGrant) else $error("grant with latch clear");
   property p_grant;
      modifyReq && writeEnableLatch |=> modifyGrant && !writeEnableLatch;
   endproperty
   a_grant: assert property (p_grant) else $error("grant or latch clear missing");
   property p_idleOe; csPinN [*5] |-> ioOe == 4'h0; endproperty
   a_idleOe: assert property (p_idleOe) else $error("drive while deselected");
   property p_setQuiet; $rose(writeEnableLatch) |-> ioOe == 4'h0; endproperty
   a_setQuiet: assert property (p_setQuiet) else $error("drive on latch set");
   property p_busyCause; $rose(busy) |-> pageLoadStart || $past(pageLoadStart); endproperty
   a_busyCause: assert property (p_busyCause) else $error("busy without load");
   property p_busyHold; $rose(busy) |-> busy [*8]; endproperty
   a_busyHold: assert property (p_busyHold) else $error("busy too short");
   property p_abort; pageLoadAbort |-> ##[0:1] (!busy && !writeEnableLatch); endproperty
   a_abort: assert property (p_abort) else $error("abort left busy or latch");
   // A new command may reload the column, so only a move away from the top is judged
   property p_wrap;
      $changed(cacheAddr) && $past(cacheAddr) == snl_pkg::CACHE_LAST |-> cacheAddr == 12'h000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("column did not wrap");
endmodule
bind snl_latch_read snl_chk i_chk (.clk, .nrst, .csPinN, .ioOe, .modifyReq, .modifyGrant,
   .pageLoadStart, .pageLoadAbort, .cacheAddr, .writeEnableLatch, .busy);

// File: test/snl_host_model.sv
`timescale 1ns/100ps
module snl_host_model (
   // Clock
   input wire logic clk,
   // Link pins
   output logic sclkPin,
   output logic csPinN,
   output logic [3:0] ioIn,
   input wire logic [3:0] ioOut,
   input wire logic [3:0] ioOe
);
   logic [3:0] hostVal, hostOe, junk;
   logic lvl;
   logic [7:0] rx[$];
   initial begin
      sclkPin = 1'b0;
      csPinN = 1'b1;
      hostVal = 4'h0;
      hostOe = 4'h0;
      junk = 4'h5;
      lvl = 1'b0;
   end
   // Released lines toggle so a stale level never passes for data
   always @(posedge clk) junk <= ~junk;
   always_comb for (int i = 0; i < 4; i++)
      ioIn[i] = ioOe[i] ? ioOut[i] : hostOe[i] ? hostVal[i] : junk[i];
   task automatic half(input logic l);
      repeat (4) @(posedge clk);
      sclkPin <= l;
      lvl = l;
   endtask
   task automatic sbit(input logic v);
      hostVal <= {3'h7, v};
      hostOe <= 4'hf;
      half(1'b1);
      half(1'b0);
   endtask
   task automatic xfer(input logic [7:0] op, input int ab, input logic [31:0] a, input int dum,
         input int nb, input int ln, input logic keep);
      logic [7:0] b;
      @(posedge clk);
      csPinN <= 1'b0;
      repeat (2) @(posedge clk);
      for (int i = 7; i >= 0; i--) sbit(op[i]);
      if (ln == 8) for (int i = 7; i >= 0; i--) begin
         // Nibble moves mid-half so the synchronised edge never sees the next one
         repeat (2) @(posedge clk);
         hostVal <= a[4*i+:4];
         repeat (2) @(posedge clk);
         sclkPin <= (i % 2 == 1);
         lvl = (i % 2 == 1);
      end
      else for (int i = ab - 1; i >= 0; i--) sbit(a[i]);
      for (int i = 0; i < dum; i++) sbit(1'b0);
      hostOe <= 4'h0;
      if (ln == 8 && nb > 0) half(1'b1);
      for (int n = 0; n < nb; n++) begin
         b = 8'h00;
         for (int k = 0; k < ((ln == 8) ? 2 : 8 / ln); k++) begin
            half((ln == 8) ? !lvl : 1'b1);
            // One spare cycle after the edge; the value read was launched on the previous edge
            @(posedge clk);
            b = (ln == 1) ? {b[6:0], ioIn[1]} : (ln == 2) ? {b[5:0], ioIn[1:0]} : {b[3:0], ioIn};
            if (ln != 8) half(1'b0);
         end
         if (keep) rx.push_back(b);
      end
      if (lvl) half(1'b0);
      repeat (4) @(posedge clk);
      csPinN <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
endmodule

// File: test/test_snl_latch_read.sv
`timescale 1ns/100ps
module test_snl_latch_read;
   // Arbitrary identification values
   localparam logic [7:0] MAKER = 8'h3c;
   localparam logic [7:0] PART = 8'hc3;
   localparam logic [7:0] OPS [5] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hee};
   localparam int LNS [5] = '{1, 1, 2, 4, 8};
   logic clk, nrst, sclkPin, csPinN, quadLinesEnable, otpAccessEnable, modifyReq;
   logic modifyGrant, pageLoadStart, pageLoadAbort, writeEnableLatch, busy, sawAbort, sawOe;
   logic [3:0] ioIn, ioOut, ioOe;
   logic [127:0] uniqueIdentifier;
   logic [23:0] pageLoadAddr, pg;
   logic [11:0] cacheAddr;
   logic [7:0] cacheData;
   logic [7:0] expQ[$];
   int failCount, checks, seed, busyCnt, lastBusy;
   snl_latch_read #(.MAKER_CODE(MAKER), .PART_CODE_BYTE(PART)) i_dut (.clk, .nrst, .sclkPin,
      .csPinN, .ioIn, .ioOut, .ioOe, .quadLinesEnable, .otpAccessEnable, .uniqueIdentifier,
      .modifyReq, .modifyGrant, .pageLoadStart, .pageLoadAddr, .pageLoadAbort, .cacheAddr,
      .cacheData, .writeEnableLatch, .busy);
   snl_host_model i_host (.clk, .sclkPin, .csPinN, .ioIn, .ioOut, .ioOe);
   function automatic logic [7:0] cval(input logic [11:0] a);
      return a[7:0] ^ {a[11:8], 4'h9};
   endfunction
   // Cache answers in the same cycle as the address register moves
   assign cacheData = cval(cacheAddr);
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      checks++;
      if (g !== e) begin
         failCount++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic giveVerdict();
      $display("checks %0d failures %0d", checks, failCount);
      if (failCount == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic waitIdle();
      for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
      chk("busy end", 0, busy);
      if (busy !== 1'b0) giveVerdict();
      else @(posedge clk);
   endtask
   task automatic req(input logic e);
      @(posedge clk);
      modifyReq <= 1'b1;
      @(posedge clk);
      modifyReq <= 1'b0;
      #1 chk("grant", e, modifyGrant);
      chk("latch after request", 0, writeEnableLatch);
   endtask
   // Identifier page: bit 4 of the column picks the complement half
   task automatic rd(input logic [7:0] op, input logic [11:0] c, input int ln, input logic unique_identifier);
      logic [11:0] a;
      a = c;
      for (int n = 0; n < 4; n++) begin
         expQ.push_back(!unique_identifier ? cval(a)
                        : {8{a[4]}} ^ uniqueIdentifier[127-8*a[3:0]-:8]);
         a = (a == snl_pkg::CACHE_LAST) ? 12'h000 : a + 12'h001;
      end
      i_host.xfer(op, (ln == 8) ? 32 : 16, {20'h0, c}, 8, 4, ln, 1'b1);
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      busyCnt <= busy ? busyCnt + 1 : 0;
      if (!busy && busyCnt != 0) lastBusy <= busyCnt;
      if (pageLoadAbort) sawAbort <= 1'b1;
      if (ioOe != 4'h0) sawOe <= 1'b1;
      if (i_host.rx.size() != 0) begin
         chk("byte", expQ.size() != 0 ? expQ.pop_front() : 8'hxx, i_host.rx.pop_front());
      end
   end
   initial begin
      seed = 90987;
      {nrst, modifyReq, quadLinesEnable, otpAccessEnable, sawAbort, sawOe} = 6'h00;
      uniqueIdentifier = {$random(seed), $random(seed), $random(seed), $random(seed)};
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      chk("idle drive", 0, ioOe);
      req(1'b0);
      i_host.xfer(8'h06, 0, 0, 0, 0, 1, 1'b1);
      chk("latch set", 1, writeEnableLatch);
      req(1'b1);
      for (int k = 0; k < 2; k++) begin
         i_host.xfer(8'h06, 0, 0, 0, 0, 1, 1'b1);
         i_host.xfer(k ? 8'hff : 8'h04, 0, 0, 0, 0, 1, 1'b1);
         chk("latch clear", 0, writeEnableLatch);
      end
      pg = 24'($random(seed)) | 24'h000100;
      i_host.xfer(8'h13, 24, {8'h00, pg}, 0, 0, 1, 1'b1);
      chk("load address", pg, pageLoadAddr);
      expQ.push_back(8'h01);
      i_host.xfer(8'h0f, 8, 32'hc0, 0, 1, 1, 1'b1);
      waitIdle();
      chk("busy time", snl_pkg::ARRAY_BUSY_CYC, lastBusy);
      for (int k = 3; k < 5; k++) begin
         sawOe <= 1'b0;
         i_host.xfer(OPS[k], 16 * (k - 2), 0, 8, 2, LNS[k], 1'b0);
         chk("refused drive", 0, sawOe);
      end
      quadLinesEnable <= 1'b1;
      for (int m = 0; m < 5; m++) begin
         rd(OPS[m], (m == 4) ? snl_pkg::CACHE_LAST - 12'h001 : 12'($random(seed)) & 12'h3ff,
            LNS[m], 1'b0);
      end
      expQ.push_back(MAKER);
      expQ.push_back(PART);
      i_host.xfer(8'h9f, 0, 0, 8, 2, 1, 1'b1);
      sawAbort <= 1'b0;
      i_host.xfer(8'h13, 24, {8'h00, pg}, 0, 0, 1, 1'b1);
      i_host.xfer(8'hff, 0, 0, 0, 0, 1, 1'b1);
      chk("abort seen", 1, sawAbort);
      chk("busy after abort", 0, busy);
      otpAccessEnable <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         i_host.xfer(8'h13, 24, k ? 32'h4 : 32'h6, 0, 0, 1, 1'b1);
         waitIdle();
         rd(OPS[k], 12'h01e, 1, k == 0);
      end
      repeat (2) @(posedge clk);
      chk("pending bytes", 0, expQ.size());
      giveVerdict();
   end
endmodule
